// file: rtl/mcs_pkg.sv
package mcs_pkg;

    // ------------------------------------------------------------------
    // Clock and chopper timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int BLANK_TIME_NS = 1000;
    localparam int FAST_TAIL_NS = 1000;
    // Blanking is a least time, so it rounds up.
    localparam int BLANK_CYC = (BLANK_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // The fast tail is approximate, so it rounds down.
    localparam int FAST_CYC = FAST_TAIL_NS / CLK_PERIOD_NS;
    localparam logic [6:0] BLANK_LAST = 7'(BLANK_CYC - 1);
    localparam logic [16:0] FAST_TAIL_CYC = 17'(FAST_CYC);
    localparam logic [15:0] PERIOD_MAX = 16'hFFFF;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] LEVEL_ADDR = 8'h08;
    localparam int CTRL_DIR_BIT = 0;
    localparam int CTRL_SEL_LOW_BIT = 1;
    localparam int CTRL_SEL_HIGH_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Excitation modes and positions
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_HALF = 2'h1;
    localparam logic [1:0] MODE_FOUR = 2'h2;
    localparam logic [1:0] MODE_EIGHT = 2'h3;
    localparam logic [6:0] INC_FULL = 7'h20;
    localparam logic [6:0] INC_HALF = 7'h10;
    localparam logic [6:0] INC_FOUR = 7'h02;
    localparam logic [6:0] INC_EIGHT = 7'h01;
    localparam logic [6:0] POS_INIT_FULL = 7'h70;
    localparam logic [6:0] POS_INIT_MICRO = 7'h00;
    localparam logic [6:0] QUARTER = 7'h20;
    localparam logic [6:0] LEVEL_FULL = 7'h64;

    // ------------------------------------------------------------------
    // Chopper states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        MCS_IDLE = 5'h01,
        MCS_BLANK = 5'h02,
        MCS_CHARGE = 5'h04,
        MCS_SLOW = 5'h08,
        MCS_FAST = 5'h10
    } mcs_chop_state_t;

endpackage

// file: rtl/mcs_sequencer.sv
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
// How it works
// - In micro modes position 32 gives channel one 0 and channel two 100.
// - A rising chopping tick starts a new period in the blanking state.
// - Each period opens with 1 us of forced charge, the blanking time.
// - Blanking records whether coil current was ever below target.
// - If so, charge runs to target, then slow decay, then about 1 us fast.
// - If it never was, fast decay follows blanking until the period ends.
// - Each rising step edge moves the position by 32, 16, 2 or 1 entries (full, half, four, eight).
// - Channel two lags channel one by 90 deg forward and leads in reverse.
// - Two select bits pick the stepping mode and its start point.
// - Position reset low holds the start point with the home flag on.
module mcs_sequencer
    import mcs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic pos_reset_n_i,
    input wire logic advance_pulse_input_i,
    input wire logic chop_tick_i,
    input wire logic coil_below_target_i,
    input wire logic home_pin_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [6:0] ch1_level_o,
    output logic ch1_negative_o,
    output logic [6:0] ch2_level_o,
    output logic ch2_negative_o,
    output logic home_position_flag_o,
    output logic home_pin_o,
    output logic home_pin_oe_n_o,
    output logic chop_charge_o,
    output logic chop_slow_o,
    output logic chop_fast_o
);

    // ------------------------------------------------------------------
    // Quarter-cycle table and channel level
    // ------------------------------------------------------------------
    function automatic logic [6:0] quarter_level(input logic [5:0] k);
        logic [6:0] v;
        v = 7'h00;
        case (k)
            6'h00, 6'h01, 6'h02: v = 7'h64;
            6'h03: v = 7'h63;
            6'h04: v = 7'h62;
            6'h05: v = 7'h61;
            6'h06: v = 7'h60;
            6'h07: v = 7'h5E;
            6'h08: v = 7'h5C;
            6'h09: v = 7'h5A;
            6'h0A: v = 7'h58;
            6'h0B: v = 7'h56;
            6'h0C: v = 7'h53;
            6'h0D: v = 7'h50;
            6'h0E: v = 7'h4D;
            6'h0F: v = 7'h4A;
            6'h10: v = 7'h46;
            6'h11: v = 7'h43;
            6'h12: v = 7'h3F;
            6'h13: v = 7'h3C;
            6'h14: v = 7'h37;
            6'h15: v = 7'h33;
            6'h16: v = 7'h2F;
            6'h17: v = 7'h2B;
            6'h18: v = 7'h26;
            6'h19: v = 7'h22;
            6'h1A: v = 7'h1D;
            6'h1B: v = 7'h18;
            6'h1C: v = 7'h14;
            6'h1D: v = 7'h0F;
            6'h1E: v = 7'h0A;
            6'h1F: v = 7'h05;
            default: v = 7'h00;
        endcase
        return v;
    endfunction

    // Cosine of a 7-bit angle: {negative, level}. Odd quadrants mirror.
    function automatic logic [7:0] cos_level(input logic [6:0] a,
                                             input logic full);
        logic [5:0] k;
        logic [6:0] mag;
        k = a[5] ? 6'h20 - {1'b0, a[4:0]} : {1'b0, a[4:0]};
        mag = full ? LEVEL_FULL : quarter_level(k);
        return {(a[6] ^ a[5]) & (mag != 7'h00), mag};
    endfunction

    // ------------------------------------------------------------------
    // Registers and edge detection
    // ------------------------------------------------------------------
    logic step_d_reg;
    logic tick_d_reg;
    logic [2:0] ctrl_reg;
    logic [6:0] pos_reg;
    logic [6:0] pos_next;
    mcs_chop_state_t state_reg;
    mcs_chop_state_t state_next;
    logic [6:0] blank_cnt_reg;
    logic [6:0] blank_cnt_next;
    logic seen_reg;
    logic seen_next;
    logic [15:0] per_cnt_reg;
    logic [15:0] per_cnt_next;
    logic [15:0] last_per_reg;
    logic [15:0] last_per_next;

    wire step_rise = advance_pulse_input_i & ~step_d_reg;
    wire tick_rise = chop_tick_i & ~tick_d_reg;
    wire dir_reverse = ctrl_reg[CTRL_DIR_BIT];
    wire [1:0] mode = {ctrl_reg[CTRL_SEL_HIGH_BIT],
                       ctrl_reg[CTRL_SEL_LOW_BIT]};
    wire mode_full = (mode == MODE_FULL);

    // ------------------------------------------------------------------
    // Position sequencer
    // ------------------------------------------------------------------
    wire [6:0] init_pos = mode_full ? POS_INIT_FULL : POS_INIT_MICRO;
    wire [6:0] step_inc = (mode == MODE_EIGHT) ? INC_EIGHT :
                          (mode == MODE_FOUR) ? INC_FOUR :
                          (mode == MODE_HALF) ? INC_HALF : INC_FULL;
    // Reverse walks the angle backwards so channel two leads.
    wire [6:0] stepped = dir_reverse ? pos_reg - step_inc
                                     : pos_reg + step_inc;

    assign pos_next = !pos_reset_n_i ? init_pos :
                      step_rise ? stepped : pos_reg;
    wire home_next = (pos_next == init_pos);
    wire [7:0] ch1_next = cos_level(pos_next, mode_full);
    // Channel two is the sine, so it sits one quarter behind.
    wire [7:0] ch2_next = cos_level(pos_next - QUARTER, mode_full);

    // ------------------------------------------------------------------
    // Chopping controller
    // ------------------------------------------------------------------
    wire blank_done = (blank_cnt_reg == BLANK_LAST);
    wire seen_now = seen_reg | coil_below_target_i;
    // The previous period length predicts when the next tick is due.
    wire tail_due = ({1'b0, per_cnt_reg} + FAST_TAIL_CYC)
                    >= {1'b0, last_per_reg};

    always_comb
    begin
        state_next = state_reg;
        if (tick_rise)
        begin
            state_next = MCS_BLANK;
        end
        else
        begin
            case (state_reg)
                MCS_IDLE: state_next = MCS_IDLE;
                MCS_BLANK:
                begin
                    if (blank_done)
                    begin
                        if (!seen_now)
                            state_next = MCS_FAST;
                        else if (coil_below_target_i)
                            state_next = MCS_CHARGE;
                        else
                            state_next = MCS_SLOW;
                    end
                end
                MCS_CHARGE:
                begin
                    if (!coil_below_target_i)
                        state_next = MCS_SLOW;
                end
                MCS_SLOW:
                begin
                    if (tail_due)
                        state_next = MCS_FAST;
                end
                MCS_FAST: state_next = MCS_FAST;
                default: state_next = MCS_IDLE;
            endcase
        end
    end

    assign blank_cnt_next = tick_rise ? 7'h00 :
        (state_reg == MCS_BLANK && !blank_done) ? blank_cnt_reg + 7'h01 :
        blank_cnt_reg;
    assign seen_next = tick_rise ? 1'b0 :
        (state_reg == MCS_BLANK) ? seen_now : seen_reg;
    assign per_cnt_next = tick_rise ? 16'h0000 :
        (per_cnt_reg == PERIOD_MAX) ? per_cnt_reg : per_cnt_reg + 16'h0001;
    // A tick out of idle has no real previous period, so the first period tails
    // only from count 65410 on; a saturated count must not wrap to a zero length.
    assign last_per_next = !tick_rise ? last_per_reg :
        (state_reg == MCS_IDLE || per_cnt_reg == PERIOD_MAX) ? PERIOD_MAX :
        per_cnt_reg + 16'h0001;

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    wire wb_access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire ctrl_write = wb_access & wb_we_i & wb_sel_i[0]
                      & (wb_adr_i == CTRL_ADDR);
    wire [2:0] ctrl_next = ctrl_write ? wb_dat_i[2:0] : ctrl_reg;
    wire [31:0] status_word = {16'h0000, home_pin_i, state_reg,
                               seen_reg, home_position_flag_o, 1'b0,
                               pos_reg};
    wire [31:0] level_word = {16'h0000, ch2_negative_o, ch2_level_o,
                              ch1_negative_o, ch1_level_o};
    wire [31:0] read_word = (wb_adr_i == CTRL_ADDR) ? {29'h0, ctrl_reg} :
                            (wb_adr_i == STATUS_ADDR) ? status_word :
                            (wb_adr_i == LEVEL_ADDR) ? level_word :
                            32'h0000_0000;
    wire [31:0] dat_next = (wb_access & ~wb_we_i) ? read_word : 32'h0;

    // ------------------------------------------------------------------
    // State update
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            step_d_reg <= 1'b0;
            tick_d_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
            pos_reg <= POS_INIT_FULL;
            state_reg <= MCS_IDLE;
            blank_cnt_reg <= 7'h00;
            seen_reg <= 1'b0;
            per_cnt_reg <= 16'h0000;
            last_per_reg <= PERIOD_MAX;
        end
        else if (ce_i)
        begin
            step_d_reg <= advance_pulse_input_i;
            tick_d_reg <= chop_tick_i;
            ctrl_reg <= ctrl_next;
            pos_reg <= pos_next;
            state_reg <= state_next;
            blank_cnt_reg <= blank_cnt_next;
            seen_reg <= seen_next;
            per_cnt_reg <= per_cnt_next;
            last_per_reg <= last_per_next;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            {ch1_negative_o, ch1_level_o} <= {1'b0, LEVEL_FULL};
            {ch2_negative_o, ch2_level_o} <= {1'b1, LEVEL_FULL};
            home_position_flag_o <= 1'b1;
            home_pin_o <= 1'b0;
            home_pin_oe_n_o <= 1'b0;
            chop_charge_o <= 1'b0;
            chop_slow_o <= 1'b0;
            chop_fast_o <= 1'b0;
        end
        else if (ce_i)
        begin
            wb_ack_o <= wb_access;
            wb_dat_o <= dat_next;
            {ch1_negative_o, ch1_level_o} <= ch1_next;
            {ch2_negative_o, ch2_level_o} <= ch2_next;
            home_position_flag_o <= home_next;
            home_pin_oe_n_o <= ~home_next;
            chop_charge_o <= state_next == MCS_BLANK
                             || state_next == MCS_CHARGE;
            chop_slow_o <= state_next == MCS_SLOW;
            chop_fast_o <= state_next == MCS_FAST;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i || !ce_i);

    sequence tick_seen;
        tick_rise && ce_i;
    endsequence

    sequence blank_started;
        state_reg == MCS_BLANK && chop_charge_o;
    endsequence

    a_tick_starts_blank: assert property (
        tick_seen |=> blank_started)
        else $error("Tick did not start a blanking charge.");

    a_blank_forces_charge: assert property (
        (tick_seen ##1 (!tick_rise && ce_i) [*7]) |-> chop_charge_o)
        else $error("Charge dropped early in blanking.");

    a_blank_exit_count: assert property (
        (state_reg == MCS_BLANK && state_next != MCS_BLANK)
            |-> (blank_cnt_reg == BLANK_LAST || tick_rise))
        else $error("Blanking left before its full count.");

    a_blank_records_low: assert property (
        (state_reg == MCS_BLANK && coil_below_target_i && !tick_rise)
            |=> seen_reg)
        else $error("Low coil current in blanking not recorded.");

    a_charge_then_slow: assert property (
        (state_reg == MCS_CHARGE && !coil_below_target_i && !tick_rise)
            |=> chop_slow_o && !chop_charge_o)
        else $error("Charge did not give way to slow decay.");

    a_no_low_fast: assert property (
        (state_reg == MCS_BLANK && blank_done && !seen_now && !tick_rise)
            |=> chop_fast_o ##1 (chop_fast_o || $past(tick_rise)))
        else $error("Fast decay missing after clean blanking.");

    a_step_advances: assert property (
        (step_rise && pos_reset_n_i && mode == MODE_EIGHT && !dir_reverse
            && !ctrl_write) |=> pos_reg == $past(pos_reg) + 7'h01)
        else $error("Step edge did not advance one position.");

    a_reverse_steps: assert property (
        (step_rise && pos_reset_n_i && mode == MODE_FOUR && dir_reverse
            && !ctrl_write) |=> pos_reg == $past(pos_reg) - 7'h02)
        else $error("Reverse step went the wrong way.");

    a_reset_home: assert property (
        !pos_reset_n_i |=> home_position_flag_o && !home_pin_oe_n_o
            && pos_reg == $past(init_pos))
        else $error("Position reset did not reach home.");

    a_quarter_end: assert property (
        (pos_reg == QUARTER && !mode_full && $stable(pos_reg)
            && $stable(ctrl_reg)) |-> ch1_level_o == 7'h00
            && ch2_level_o == LEVEL_FULL && !ch2_negative_o)
        else $error("Quarter end levels wrong.");

    a_table_entry: assert property (
        (pos_reg == 7'h12 && mode == MODE_EIGHT && $stable(pos_reg)
            && $stable(ctrl_reg)) |-> ch1_level_o == 7'h3F
            && ch2_level_o == 7'h4D)
        else $error("Position 18 levels wrong.");

    a_wrap_revolution: assert property (
        (pos_reg == 7'h7F && step_rise && pos_reset_n_i && !dir_reverse
            && mode == MODE_EIGHT && !ctrl_write) |=> pos_reg == 7'h00
            ##1 (ch1_level_o == 7'h64 || !$stable(pos_reg)))
        else $error("Revolution did not wrap to start.");

endmodule

// file: bench/mcs_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Step pulse source
// ------------------------------------------------------------------
// Each step is one cycle high and one cycle low, so every pulse
// is a clean rising edge that the sequencer can see.
module mcs_host_model
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic req_i,
    input wire logic [7:0] count_i,
    output logic advance_pulse_input_o,
    output logic busy_o
);
    logic [7:0] left_reg;
    assign busy_o = (left_reg != 8'h00) || advance_pulse_input_o;
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            left_reg <= 8'h00;
            advance_pulse_input_o <= 1'b0;
        end
        else if (req_i && !busy_o)
            left_reg <= count_i;
        else if (left_reg != 8'h00)
        begin
            advance_pulse_input_o <= !advance_pulse_input_o;
            if (advance_pulse_input_o)
                left_reg <= left_reg - 8'h01;
        end
    end
endmodule

// file: bench/microstep_chopper_sequencer_tb_top.sv
`timescale 1ns/1ps
module microstep_chopper_sequencer_tb_top;
    import mcs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, prst_n = 1'b1, tick = 1'b0;
    logic below = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
    logic req = 1'b0, advance_pulse_input, busy, pin_o, oe_n, home_wire;
    logic [7:0] adr = 8'h00, cnt = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, charge, slow, fast, home, n1, n2;
    logic [6:0] l1, l2;
    int fail_count = 0, checks_done = 0;
    logic [6:0] tab1 [0:14] = '{7'h3F, 7'h3C, 7'h37, 7'h33, 7'h2F,
        7'h2B, 7'h26, 7'h22, 7'h1D, 7'h18, 7'h14, 7'h0F, 7'h0A,
        7'h05, 7'h00};
    logic [6:0] tab2 [0:14] = '{7'h4D, 7'h50, 7'h53, 7'h56, 7'h58,
        7'h5A, 7'h5C, 7'h5E, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64,
        7'h64, 7'h64};
    // Open-drain home wire with a pull-up when released.
    assign home_wire = oe_n ? 1'b1 : pin_o;
    always #4 clk = ~clk;
    mcs_host_model host (.clk_sys_i(clk), .sys_rst_i(rst), .req_i(req),
        .count_i(cnt), .advance_pulse_input_o(advance_pulse_input), .busy_o(busy));
    mcs_sequencer dut (.clk_sys_i(clk), .sys_rst_i(rst), .ce_i(ce),
        .pos_reset_n_i(prst_n), .advance_pulse_input_i(advance_pulse_input),
        .chop_tick_i(tick), .coil_below_target_i(below),
        .home_pin_i(home_wire), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ch1_level_o(l1),
        .ch1_negative_o(n1), .ch2_level_o(l2), .ch2_negative_o(n2),
        .home_position_flag_o(home), .home_pin_o(pin_o),
        .home_pin_oe_n_o(oe_n), .chop_charge_o(charge),
        .chop_slow_o(slow), .chop_fast_o(fast));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic lv(input logic [6:0] a, input logic na,
        input logic [6:0] b, input logic nb);
        chk({n1, l1, n2, l2}, {na, a, nb, b});
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20)
            chk(32'h0, 32'h1);
    endtask
    task automatic steps(input logic [7:0] n);
        int k;
        @(posedge clk);
        req <= 1'b1;
        cnt <= n;
        @(posedge clk);
        req <= 1'b0;
        #1;
        k = 0;
        while (busy === 1'b1 && k < 600)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 600)
            chk(32'h0, 32'h1);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic home_at(input logic [2:0] mode);
        wb(1'b1, CTRL_ADDR, {29'h0, mode});
        @(posedge clk);
        prst_n <= 1'b0;
        repeat (3) @(posedge clk);
        prst_n <= 1'b1;
        @(posedge clk);
        #1;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_eight;
        home_at(3'h6);
        lv(7'h64, 1'b0, 7'h00, 1'b0);
        chk({home, oe_n}, 2'h2);
        wb(1'b0, STATUS_ADDR, 32'h0);
        chk({q[15], q[8], q[6:0]}, 9'h080);
        wb(1'b0, CTRL_ADDR, 32'h0);
        chk(q, 32'h0000_0006);
        wb(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h0);
        steps(8'h12);
        for (int i = 0; i < 15; i++)
        begin
            lv(tab1[i], 1'b0, tab2[i], 1'b0);
            if (i < 14)
                steps(8'h01);
        end
        chk({home, oe_n}, 2'h1);
        wb(1'b0, STATUS_ADDR, 32'h0);
        chk({q[15], q[8], q[6:0]}, 9'h120);
        wb(1'b0, LEVEL_ADDR, 32'h0);
        chk(q, 32'h0000_6400);
        steps(8'h20);
        lv(7'h64, 1'b1, 7'h00, 1'b0);
        steps(8'h40);
        lv(7'h64, 1'b0, 7'h00, 1'b0);
        chk(home, 1'b1);
    endtask
    task automatic t_modes;
        home_at(3'h4);
        steps(8'h10);
        lv(7'h00, 1'b0, 7'h64, 1'b0);
        home_at(3'h2);
        steps(8'h02);
        lv(7'h00, 1'b0, 7'h64, 1'b0);
        home_at(3'h7);
        steps(8'h12);
        lv(7'h3F, 1'b0, 7'h4D, 1'b1);
        home_at(3'h5);
        steps(8'h09);
        lv(7'h3F, 1'b0, 7'h4D, 1'b1);
    endtask
    task automatic t_full;
        home_at(3'h0);
        lv(7'h64, 1'b0, 7'h64, 1'b1);
        steps(8'h01);
        lv(7'h64, 1'b0, 7'h64, 1'b0);
        chk(home, 1'b0);
        steps(8'h01);
        lv(7'h64, 1'b1, 7'h64, 1'b0);
    endtask
    // Steps offered while the clock enable is low must not move anything.
    task automatic t_hold;
        @(posedge clk);
        ce <= 1'b0;
        steps(8'h02);
        lv(7'h64, 1'b1, 7'h64, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
    endtask
    task automatic chop_period(input logic cmp);
        for (int c = 0; c < 400; c++)
        begin
            @(posedge clk);
            tick <= (c < 4);
            below <= cmp && (c < 200);
            #1;
            if (c == 1 || c == 125)
                chk({charge, slow, fast}, 3'h4);
            if (!cmp && (c == 126 || c == 399))
                chk({charge, slow, fast}, 3'h1);
            if (cmp && c == 199)
                chk({charge, slow, fast}, 3'h4);
            if (cmp && (c == 210 || c == 250))
                chk({charge, slow, fast}, 3'h2);
            if (cmp && (c == 300 || c == 399))
                chk({charge, slow, fast}, 3'h1);
        end
    endtask
    task automatic results;
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        lv(7'h64, 1'b0, 7'h64, 1'b1);
        chk({charge, slow, fast, home}, 4'h1);
        t_eight;
        t_modes;
        t_full;
        t_hold;
        chop_period(1'b0);
        chop_period(1'b1);
        results;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results;
    end
endmodule
